//--- csf_frame_slot.sv
// The placing of the registers and the APB register port are this design's own decisions.
`default_nettype none

module csf_frame_slot #(
   parameter logic [3:0] VERSION = 4'h1
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        bit_clock_in,
   output logic             bit_clock_out,
   output logic             bit_clock_oe,
   input  wire logic        frame_sync_in,
   output logic             frame_sync_out,
   output logic             frame_sync_oe,
   output logic             serial_data_out,
   output logic             unbuffered_serial_out,
   output logic             unbuffered_serial_oe,
   output logic             control_data_out
);

   // ----------------------------------------------------------------
   // configuration and decode
   // ----------------------------------------------------------------
   logic [8:0]       ctrl_reg;
   csf_pkg::csf_fmt_t fmt;
   logic             master;
   logic             fmt34;
   logic [3:0]       sub_log;
   logic [3:0]       fr_log;
   logic [1:0]       nsub_log;
   logic [1:0]       slot;
   logic [7:0]       fr_last;

   // a floating third select arrives as low, keeping formats 1 to 3
   always_comb begin
      if (ctrl_reg[2]) begin
         fmt = csf_pkg::CSF_F4;
      end else begin
         case (ctrl_reg[1:0])
            2'h0:    fmt = csf_pkg::CSF_F1;
            2'h1:    fmt = csf_pkg::CSF_F2;
            default: fmt = csf_pkg::CSF_F3;
         endcase
      end
   end

   // geometry of frame and sub-frame
   assign fmt34    = fmt == csf_pkg::CSF_F3 || fmt == csf_pkg::CSF_F4;
   assign master   = ctrl_reg[3] && fmt34;
   assign sub_log  = (fmt == csf_pkg::CSF_F4) ? csf_pkg::LOG32
                                               : csf_pkg::LOG64;
   assign fr_log   = csf_pkg::frame_log(fmt, master, ctrl_reg[5:4]);
   assign nsub_log = 2'(fr_log - sub_log);
   assign fr_last  = 8'((9'h001 << fr_log) - 9'h001);

   // slot choice by the number of sub-frames present
   always_comb begin
      case (nsub_log)
         2'h2:    slot = ctrl_reg[7:6];
         2'h1:    slot = {1'b0, |ctrl_reg[7:6]};
         default: slot = 2'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // bit clock and frame sync sampling
   // ----------------------------------------------------------------
   logic       bclk_s;
   logic       fs_s;
   logic       bclk_d_reg;
   logic [2:0] div_reg;
   logic       tick;
   logic       bit_rise;

   csf_sync3 u_bclk_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (bit_clock_in),
      .q       (bclk_s)
   );

   csf_sync3 u_fs_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (frame_sync_in),
      .q       (fs_s)
   );

   // host clocks must track pclk, else edges get lost here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bclk_d_reg <= 1'b0;
      end else begin
         bclk_d_reg <= bclk_s;
      end
   end

   // master bit clock is a divider of pclk
   assign tick = div_reg == 3'(csf_pkg::BCLK_HALF - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg       <= 3'h0;
         bit_clock_out <= 1'b0;
      end else if (!master) begin
         div_reg       <= 3'h0;
         bit_clock_out <= 1'b0;
      end else begin
         div_reg <= tick ? 3'h0 : div_reg + 3'h1;
         if (tick) begin
            bit_clock_out <= !bit_clock_out;
         end
      end
   end

   assign bit_rise = master ? (tick && !bit_clock_out)
                            : (bclk_s && !bclk_d_reg);

   // ----------------------------------------------------------------
   // frame start detection
   // ----------------------------------------------------------------
   logic       fs_prev_reg;
   logic [1:0] run_reg;
   logic [7:0] pos_reg;
   logic       valid_reg;
   logic       start_sl;
   logic       start;

   // fmt 1/2 wait two high bit clocks; no per-word pulses are needed
   assign start_sl = fmt34 ? (fs_s && !fs_prev_reg)
                           : (fs_s && run_reg == 2'(csf_pkg::RUN_START - 1));
   assign start    = master ? (!valid_reg || pos_reg == fr_last) : start_sl;

   // sync sampled once per bit clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_prev_reg <= 1'b0;
         run_reg     <= 2'h0;
      end else if (bit_rise) begin
         fs_prev_reg <= fs_s;
         if (!fs_s) begin
            run_reg <= 2'h0;
         end else if (run_reg != csf_pkg::RUN_START) begin
            run_reg <= run_reg + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // bit position and slot tracking
   // ----------------------------------------------------------------
   logic [7:0]  pos_next;
   logic        valid_next;
   logic [1:0]  sub_next;
   logic [5:0]  bit_next;
   logic        mine_next;
   logic [5:0]  sub_mask;

   assign sub_mask = (fmt == csf_pkg::CSF_F4) ? 6'h1f : 6'h3f;

   // a slave frame ends after its last bit and waits for sync
   always_comb begin
      pos_next   = pos_reg;
      valid_next = valid_reg;
      if (start) begin
         pos_next   = 8'h00;
         valid_next = 1'b1;
      end else if (valid_reg) begin
         pos_next = pos_reg + 8'h01;
         if (pos_reg == fr_last) begin
            valid_next = 1'b0;
         end
      end
   end

   // slot index counted from the frame start
   assign sub_next  = 2'(pos_next >> sub_log);
   assign bit_next  = pos_next[5:0] & sub_mask;
   assign mine_next = valid_next && sub_next == slot;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_reg   <= 8'h00;
         valid_reg <= 1'b0;
      end else if (bit_rise) begin
         pos_reg   <= pos_next;
         valid_reg <= valid_next;
      end
   end

   // ----------------------------------------------------------------
   // sample buffer and shifter
   // ----------------------------------------------------------------
   csf_fifo_if #(.W(32)) fq ();
   logic [31:0] word_reg;
   logic [31:0] word_next;
   logic        sd_bit;
   logic        cd_bit;
   logic        apb_wr_txd;

   csf_fifo #(
      .W     (32),
      .DEPTH (csf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .f       (fq.fifo)
   );

   // one word per frame; an empty buffer sends silence
   assign fq.out_ready = bit_rise && start;
   assign word_next = !start ? word_reg : fq.out_valid ? fq.out_data : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_reg <= 32'h0000_0000;
      end else if (bit_rise) begin
         word_reg <= word_next;
      end
   end

   // data bit for the next bit period
   always_comb begin
      sd_bit = 1'b0;
      cd_bit = 1'b0;
      if (fmt == csf_pkg::CSF_F4) begin
         sd_bit = word_next[5'(5'h1f - bit_next[4:0])];
         if (bit_next[5:2] == csf_pkg::CDO_LO[5:2]) begin
            cd_bit = VERSION[2'(2'h3 - bit_next[1:0])];
         end
      end else if (bit_next[5:2] == csf_pkg::VER_LO[5:2]) begin
         sd_bit = VERSION[2'(2'h3 - bit_next[1:0])];
      end else if (bit_next < csf_pkg::VER_LO) begin
         sd_bit = word_next[5'(5'h1f - bit_next[4:0])];
      end
   end

   // outputs move on the rising bit clock, host samples on the next rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_data_out       <= 1'b0;
         unbuffered_serial_out <= 1'b0;
         unbuffered_serial_oe  <= 1'b0;
         control_data_out      <= 1'b0;
         frame_sync_out        <= 1'b0;
      end else if (bit_rise) begin
         serial_data_out       <= mine_next && sd_bit;
         unbuffered_serial_out <= mine_next && sd_bit;
         unbuffered_serial_oe  <= mine_next;
         control_data_out      <= mine_next && cd_bit;
         frame_sync_out        <= master && start;
      end
   end

   assign bit_clock_oe  = master;
   assign frame_sync_oe = master;

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   logic apb_acc;
   logic mapped;

   assign apb_acc    = psel && penable;
   assign mapped     = paddr == csf_pkg::CTRL_OFF || paddr == csf_pkg::TXD_OFF
                       || paddr == csf_pkg::STAT_OFF;
   assign apb_wr_txd = apb_acc && pwrite && paddr == csf_pkg::TXD_OFF;
   // a full buffer stalls the master instead of dropping samples
   assign pready     = !(apb_wr_txd && !fq.in_ready);
   assign pslverr    = apb_acc && !mapped;
   assign fq.in_valid = apb_wr_txd;
   assign fq.in_data  = pwdata;

   // control writes take effect at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= csf_pkg::CTRL_RST;
      end else if (apb_acc && pwrite && paddr == csf_pkg::CTRL_OFF) begin
         ctrl_reg <= pwdata[8:0];
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            csf_pkg::CTRL_OFF: prdata <= {23'h000000, ctrl_reg};
            csf_pkg::STAT_OFF: prdata <= {16'h0000, VERSION, !fq.in_ready,
                                           !fq.out_valid, master, fmt,
                                           nsub_log, slot, 2'(pos_reg >> sub_log),
                                           valid_reg};
            default:           prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [5:0] bit_q;
   logic [1:0] sub_q;

   assign bit_q = pos_reg[5:0] & sub_mask;
   assign sub_q = 2'(pos_reg >> sub_log);

   // the output on show belongs to the position held since the last rise
   version_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      (bit_rise && $stable(ctrl_reg) && valid_reg && sub_q == slot
      && fmt != csf_pkg::CSF_F4 && bit_q[5:2] == csf_pkg::VER_LO[5:2])
      |-> serial_data_out == VERSION[2'(2'h3 - bit_q[1:0])])
      else $error("version field wrong on serial data");

   low_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_reg[2] |-> fmt != csf_pkg::CSF_F4)
      else $error("format four without third select");

   edge_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (bit_rise && !master && fmt34 && fs_s && !fs_prev_reg)
      |=> (pos_reg == 8'h00 && valid_reg))
      else $error("sync edge did not start frame");

   two_bit_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (bit_rise && !fmt34 && fs_s && run_reg == 2'(csf_pkg::RUN_START - 1))
      |=> (pos_reg == 8'h00 && valid_reg))
      else $error("two-bit sync not taken as start");

   sub_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      sub_mask == ((fmt == csf_pkg::CSF_F4) ? 6'h1f : 6'h3f)
      && (fmt34 || fr_log == csf_pkg::LOG256))
      else $error("sub-frame or frame width wrong");

   master_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      (master && fmt == csf_pkg::CSF_F4) |-> fr_log <= csf_pkg::LOG64)
      else $error("master format four frame too long");

   single_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
      nsub_log == 2'h0 |-> slot == 2'h0)
      else $error("slot select not ignored");

   slot_release_a: assert property (@(posedge pclk) disable iff (!presetn)
      (unbuffered_serial_oe && $stable(ctrl_reg)) |-> (valid_reg && sub_q == slot))
      else $error("unbuffered output driven outside slot");

   slave_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      !fmt34 |-> (!bit_clock_oe && !frame_sync_oe))
      else $error("format one or two drives sync");

   restart_a: assert property (@(posedge pclk) disable iff (!presetn)
      (bit_rise && start) |=> (pos_reg == 8'h00 && word_reg == $past(word_next)))
      else $error("position not restarted");

endmodule // csf_frame_slot

`default_nettype wire

//--- csf_pkg.sv
`default_nettype none

package csf_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] TXD_OFF  = 8'h04;
   localparam logic [7:0] STAT_OFF = 8'h08;
   localparam logic [8:0] CTRL_RST = 9'h000;

   // ----------------------------------------------------------------
   // serial format and frame geometry
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CSF_F1 = 2'b00,
      CSF_F2 = 2'b01,
      CSF_F3 = 2'b11,
      CSF_F4 = 2'b10
   } csf_fmt_t;

   localparam logic [3:0] LOG32  = 4'h5;
   localparam logic [3:0] LOG64  = 4'h6;
   localparam logic [3:0] LOG128 = 4'h7;
   localparam logic [3:0] LOG256 = 4'h8;
   localparam logic [5:0] VER_LO = 6'h1c;  // bit 29 counted from 1
   localparam logic [5:0] CDO_LO = 6'h10;  // bit 17 counted from 1
   localparam logic [1:0] RUN_START = 2'h2; // bit clocks of sync high
   localparam int         BCLK_HALF = 4;    // pclk cycles per half bit clock
   localparam int         FIFO_DEPTH = 4;

   // log2 of frame length in bits
   function automatic logic [3:0] frame_log(input csf_fmt_t f,
                                            input logic m,
                                            input logic [1:0] sel);
      logic [3:0] r;
      r = LOG256;
      case (f)
         CSF_F3: begin
            r = (sel == 2'h0) ? LOG64 : (m || sel == 2'h1) ? LOG128 : LOG256;
         end
         CSF_F4: begin
            r = (sel == 2'h0) ? LOG32 : (m || sel == 2'h1) ? LOG64 : LOG128;
         end
         default: r = LOG256;
      endcase
      return r;
   endfunction

endpackage

`default_nettype wire

//--- csf_fifo_if.sv
`default_nettype none

interface csf_fifo_if #(parameter int W = 32);
   logic [W-1:0] in_data;
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] out_data;
   logic         out_valid;
   logic         out_ready;
   modport fifo (input in_data, in_valid, out_ready,
                 output in_ready, out_data, out_valid);
   modport user (output in_data, in_valid, out_ready,
                 input in_ready, out_data, out_valid);
endinterface

`default_nettype wire

//--- csf_fifo.sv
`default_nettype none

module csf_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = csf_pkg::FIFO_DEPTH
) (
   input  wire logic pclk,
   input  wire logic presetn,
   csf_fifo_if.fifo  f
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0]   cnt_reg;
   logic          push;
   logic          pop;

   // honest flags straight from the count
   assign f.in_ready  = cnt_reg != (AW+1)'(DEPTH);
   assign f.out_valid = cnt_reg != '0;
   assign f.out_data  = mem[rd_reg];
   assign push = f.in_valid && f.in_ready;
   assign pop  = f.out_ready && f.out_valid;

   // storage has no reset, only pointers and count do
   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_reg] <= f.in_data;
      end
   end

   // pointers wrap at depth
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   fill_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count past depth");

endmodule // csf_fifo

`default_nettype wire

//--- csf_sync3.sv
`default_nettype none

module csf_sync3 (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic d,
   output logic      q
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q      <= 1'b0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q <= s3_reg;
         end
      end
   end

endmodule // csf_sync3

`default_nettype wire

//--- csf_host_model.sv
`default_nettype none

// ----------------------------------------------------------------
// host serial port: bursts of bit clock and sync, captures lines
// ----------------------------------------------------------------
module csf_host_model (
   output logic     bit_clock,
   output logic     frame_sync,
   input  wire logic sdo,
   input  wire logic usd,
   input  wire logic usoe,
   input  wire logic cdo
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [256:0] cap_sdo;
   logic [256:0] cap_usd;
   logic [256:0] cap_oe;
   logic [256:0] cap_cdo;

   // lines idle low until the first burst
   initial begin
      bit_clock  = 1'b0;
      frame_sync = 1'b0;
   end

   // clock stands low between bursts; capture bit i-1 at rise i,
   // which leaves room for the block's few cycles of sync delay
   task automatic frame(input int n, input int run);
      #20; // pin changes stay off the block's clock edges
      for (int i = 0; i <= n; i++) begin
         frame_sync = (i < run);
         #400 bit_clock = 1'b1;
         if (i > 0) begin
            cap_sdo[i-1] = sdo;
            cap_usd[i-1] = usd;
            cap_oe[i-1]  = usoe;
            cap_cdo[i-1] = cdo;
         end
         #400 bit_clock = 1'b0;
      end
      frame_sync = 1'b0;
      #800; // clock held low while the block takes the last rise
   endtask
endmodule // csf_host_model

`default_nettype wire

//--- csf_frame_slot_test.sv
`default_nettype none

module csf_frame_slot_test;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [3:0] VER = 4'ha; // arbitrary test version
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, e, bco, bcoe, fso, fsoe, sdo, usd, usoe, cdo;
   logic        h_bclk, h_fs, bclk, fs;
   int          failures, num_checks, cycles;

   // pins are two-way: whoever enables drives the wire
   assign bclk = bcoe ? bco : h_bclk;
   assign fs   = fsoe ? fso : h_fs;

   csf_frame_slot #(.VERSION(VER)) i_csf_frame_slot (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bit_clock_in(bclk), .bit_clock_out(bco), .bit_clock_oe(bcoe),
      .frame_sync_in(fs), .frame_sync_out(fso), .frame_sync_oe(fsoe),
      .serial_data_out(sdo), .unbuffered_serial_out(usd), .unbuffered_serial_oe(usoe),
      .control_data_out(cdo));

   csf_host_model i_csf_host_model (.bit_clock(h_bclk), .frame_sync(h_fs), .sdo(sdo),
      .usd(usd), .usoe(usoe), .cdo(cdo));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk1(input logic g, input logic x);
      num_checks++;
      if (g !== x) begin
         failures++;
         $display("wrong value t=%0t got %b exp %b", $time, g, x);
      end
   endtask

   task automatic chk32(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         failures++;
         $display("wrong value t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // own slot from base+off: data MSB first, version after 28 bits, or for f4 all 32 data bits and version on cdo
   task automatic check_frame(input logic [31:0] w, input int base, input int len,
                              input int off, input logic f4);
      logic x;
      for (int k = 0; k < base; k++) chk1(i_csf_host_model.cap_oe[k+off], 1'b0);
      for (int p = 0; p < len; p++) begin
         if (p < 28 || f4) x = w[31-p];
         else if (p < 32) x = VER[31-p];
         else x = 1'b0;
         chk1(i_csf_host_model.cap_oe[base+p+off], 1'b1);
         chk1(i_csf_host_model.cap_sdo[base+p+off], x);
         chk1(i_csf_host_model.cap_usd[base+p+off], x);
         if (f4 && p > 15 && p < 20)
            chk1(i_csf_host_model.cap_cdo[base+p+off], VER[19-p]);
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      apb(1'b0, csf_pkg::CTRL_OFF, 32'h0);
      chk32(r, 32'h0);
      apb(1'b0, csf_pkg::STAT_OFF, 32'h0);
      chk32({30'h0, r[8:7]}, 32'h0);
      chk32({28'h0, r[15:12]}, {28'h0, VER});
      chk1(r[10], 1'b1);
      apb(1'b0, 8'h0c, 32'h0);
      chk1(e, 1'b1);
   endtask

   task automatic t_f3_one; // long sync, slot selects ignored
      apb(1'b1, csf_pkg::CTRL_OFF, 32'hc2);
      apb(1'b1, csf_pkg::TXD_OFF, 32'hc3a5_9e17);
      i_csf_host_model.frame(64, 3);
      check_frame(32'hc3a5_9e17, 0, 64, 0, 1'b0);
   endtask

   task automatic t_f3_two; // 128-bit frame, select 01 gives slot 2
      apb(1'b1, csf_pkg::CTRL_OFF, 32'h52);
      apb(1'b1, csf_pkg::TXD_OFF, 32'h5a0f_e681);
      i_csf_host_model.frame(128, 1);
      check_frame(32'h5a0f_e681, 64, 64, 0, 1'b0);
   endtask

   task automatic t_f3_four; // 256-bit slave frame, select 11 gives slot 4
      apb(1'b1, csf_pkg::CTRL_OFF, 32'hf2);
      apb(1'b1, csf_pkg::TXD_OFF, 32'h3c96_d24b);
      i_csf_host_model.frame(256, 1);
      check_frame(32'h3c96_d24b, 192, 64, 0, 1'b0);
   endtask

   task automatic t_f1_run; // one-bit sync is no start, two bits is
      apb(1'b1, csf_pkg::CTRL_OFF, 32'h00);
      apb(1'b1, csf_pkg::TXD_OFF, 32'h9b3d_71c4);
      i_csf_host_model.frame(8, 1);
      apb(1'b0, csf_pkg::STAT_OFF, 32'h0);
      chk1(r[0], 1'b0);
      chk32({24'h0, i_csf_host_model.cap_oe[7:0]}, 32'h0);
      i_csf_host_model.frame(257, 2); // whole frame, so it ends cleanly
      check_frame(32'h9b3d_71c4, 0, 64, 1, 1'b0);
   endtask

   task automatic t_f4; // 32-bit frame, single slot
      apb(1'b1, csf_pkg::CTRL_OFF, 32'hc7);
      apb(1'b1, csf_pkg::TXD_OFF, 32'h6e21_b85d);
      i_csf_host_model.frame(32, 1);
      check_frame(32'h6e21_b85d, 0, 32, 0, 1'b1);
   endtask

   task automatic t_master; // sync period of a 64-bit master frame
      int n;
      logic prev;
      apb(1'b1, csf_pkg::CTRL_OFF, 32'h08);
      @(posedge pclk);
      chk1(bcoe, 1'b0);
      apb(1'b1, csf_pkg::CTRL_OFF, 32'h0a);
      @(posedge pclk);
      chk1(bcoe, 1'b1);
      chk1(fsoe, 1'b1);
      n = 0;
      // second pass counts edges from one sync rise to the next
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            prev = fso;
            @(posedge pclk);
            n++;
         end while (!(fso === 1'b1 && prev === 1'b0));
      end
      chk32(n, 32'd512);
      apb(1'b1, csf_pkg::CTRL_OFF, 32'h02);
      // idle bits with sync low clear the stale sync sample
      i_csf_host_model.frame(2, 0);
   endtask

   task automatic t_fifo; // fill four words, first one out first
      for (int k = 0; k < 4; k++) apb(1'b1, csf_pkg::TXD_OFF, 32'h1111_1110 * (k + 1));
      apb(1'b0, csf_pkg::STAT_OFF, 32'h0);
      chk1(r[11], 1'b1);
      chk1(r[10], 1'b0);
      i_csf_host_model.frame(64, 1);
      check_frame(32'h1111_1110, 0, 64, 0, 1'b0);
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         close_out;
      end
   end

   initial begin
      failures = 0;
      num_checks = 0;
      cycles = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_f3_one;
      t_f3_two;
      t_f3_four;
      t_f1_run;
      t_f4;
      t_master;
      t_fifo;
      close_out;
   end
endmodule // csf_frame_slot_test

`default_nettype wire
